// ---- include/smc_cfg.svh ----
// Constants for the serial motion command link and its two ends
// Function
// R1 - Write single register: code 06h, address, value
// R2 - Motion command word at 007Dh drives bits
// R3 - 0008h starts positioning; master clears with 0000h
// R4 - 4000h starts forward run at speed 0
// R5 - Clearing forward run decelerates to stop
// R6 - Multi write 10h, byte count twice registers
// R7 - Speed 0 is 32 bits at 0480h, upper first
// R8 - Multi write reply echoes address, count, new CRC
// R9 - Every frame ends CRC-16, low byte first
// R10 - Single write reply identical to query
// R11 - Act on command bits rising edge only
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
`define FC_WRITE_ONE     8'h06
`define FC_WRITE_MANY    8'h10
`define REG_MOTION       16'h007d
`define REG_SPEED0       16'h0480
`define SPEED_REG_COUNT  16'h0002
`define SPEED_BYTE_COUNT 8'h04
`define BIT_START        3
`define BIT_FORWARD      14
`define CRC_INIT         16'hffff
`define CRC_POLY         16'ha001
`define RX_MAX           13
`define RESP_LEN         4'h8
`define LEN_ONE          4'h8
`define LEN_MANY         4'hd
`define RAMP_NS          1000
`define CLK_NS           10
`define RAMP_CYCLES      (`RAMP_NS / `CLK_NS)
`define RAMP_STEP        32'h0000_0064
// Controller register offsets and fields
`define OFS_CTRL         8'h00
`define OFS_DATA         8'h04
`define OFS_SLAVE        8'h08
`define OFS_STATUS       8'h0c
`define SLAVE_RESET      8'h01
`define CTRL_GO          0
`define CTRL_KIND        1
`define ST_BUSY          0
`define ST_DONE          1
`define ST_OK            2
`endif

// ---- include/smc_pkg.sv ----
// Types and CRC helper shared by both ends
`include "smc_cfg.svh"
package smc_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_RX   = 2'b01,
		DEV_TX   = 2'b11
	} dev_state_t;
	typedef enum logic [1:0] {
		MST_IDLE = 2'b00,
		MST_SEND = 2'b01,
		MST_WAIT = 2'b11
	} mst_state_t;

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc_step
endpackage : smc_pkg

// ---- include/smc_link_if.sv ----
// Byte-level link between command master and motion device
`timescale 1ns/1ps
interface smc_link_if;
	logic [7:0] q_data;
	logic       q_valid;
	logic       q_last;
	logic [7:0] r_data;
	logic       r_valid;
	logic       r_last;
	modport master (output q_data, output q_valid, output q_last,
		input r_data, input r_valid, input r_last);
	modport device (input q_data, input q_valid, input q_last,
		output r_data, output r_valid, output r_last);
endinterface : smc_link_if

// ---- logic/motion_device.sv ----
// Motion device end: frame decode, echo reply, command bits, speed ramp
`timescale 1ns/1ps
`include "smc_cfg.svh"
module motion_device (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	smc_link_if.device       link,
	input  wire logic [7:0]  slave_addr,
	output logic      [15:0] motion_word,
	output logic      [31:0] run_speed,
	output logic             start_pulse,
	output logic             forward_active,
	output logic      [31:0] drive_speed
);
	smc_pkg::dev_state_t state_reg;
	smc_pkg::byte_t      buf_reg [`RX_MAX];
	logic [3:0]          cnt_reg;
	logic [15:0]         crc_reg;
	logic [15:0]         crc_next;
	logic                accept;
	logic                is_one;
	logic                is_many;
	logic [15:0]         word_next;
	logic                word_we;
	logic                speed_we;
	logic [3:0]          tx_idx_reg;
	logic [15:0]         tx_crc_reg;
	logic [15:0]         word_prev_reg;
	logic [15:0]         ramp_cnt_reg;
	logic                ramp_tick;
	logic [31:0]         target;

	////////////////////////////////////////////////////////////////////////
	// Receive
	assign crc_next = smc_pkg::crc_step(crc_reg, link.q_data); // [R9]
	// Frame checks on the byte that ends the frame
	assign is_one = buf_reg[1] == `FC_WRITE_ONE && cnt_reg == 4'(`LEN_ONE - 1)
		&& {buf_reg[2], buf_reg[3]} == `REG_MOTION; // [R1] [R2]
	assign is_many = buf_reg[1] == `FC_WRITE_MANY && cnt_reg == 4'(`LEN_MANY - 1)
		&& {buf_reg[2], buf_reg[3]} == `REG_SPEED0
		&& {buf_reg[4], buf_reg[5]} == `SPEED_REG_COUNT
		&& buf_reg[6] == `SPEED_BYTE_COUNT; // [R6] [R7]
	assign accept = link.q_valid && link.q_last && crc_next == 16'h0000
		&& buf_reg[0] == slave_addr && (is_one || is_many); // [R9]
	assign word_we = accept && is_one;
	assign speed_we = accept && is_many;
	assign word_next = {buf_reg[4], buf_reg[5]};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= smc_pkg::DEV_IDLE;
		end else begin
			case (state_reg)
				smc_pkg::DEV_IDLE: begin
					if (link.q_valid && !link.q_last) begin
						state_reg <= smc_pkg::DEV_RX;
					end
				end
				smc_pkg::DEV_RX: begin
					if (accept) begin
						state_reg <= smc_pkg::DEV_TX;
					end else if (link.q_valid && link.q_last) begin
						state_reg <= smc_pkg::DEV_IDLE;
					end
				end
				smc_pkg::DEV_TX: begin
					if (tx_idx_reg == `RESP_LEN - 4'h1) begin
						state_reg <= smc_pkg::DEV_IDLE;
					end
				end
				default: state_reg <= smc_pkg::DEV_IDLE;
			endcase
		end
	end

	// Bytes beyond the longest frame are dropped; the count check rejects it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 4'h0;
			crc_reg <= `CRC_INIT;
		end else if (state_reg == smc_pkg::DEV_TX) begin
			cnt_reg <= 4'h0;
			crc_reg <= `CRC_INIT;
		end else if (link.q_valid) begin
			cnt_reg <= link.q_last ? 4'h0 : (cnt_reg == 4'hf ? cnt_reg : cnt_reg + 4'h1);
			crc_reg <= link.q_last ? `CRC_INIT : crc_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < `RX_MAX; i++) begin
				buf_reg[i] <= 8'h00;
			end
		end else if (link.q_valid && state_reg != smc_pkg::DEV_TX
			&& cnt_reg < 4'(`RX_MAX)) begin
			buf_reg[cnt_reg] <= link.q_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			motion_word <= 16'h0000;
		end else if (word_we) begin
			motion_word <= word_next; // [R2]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_speed <= 32'h0000_0000;
		end else if (speed_we) begin
			// Upper word sits at the lower register address
			run_speed <= {buf_reg[7], buf_reg[8], buf_reg[9], buf_reg[10]}; // [R7]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply: first six query bytes, then a fresh CRC
	// A single write's echo equals the query because the CRC is over the same bytes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_idx_reg <= 4'h0;
			tx_crc_reg <= `CRC_INIT;
		end else if (state_reg == smc_pkg::DEV_TX) begin
			tx_idx_reg <= tx_idx_reg + 4'h1;
			if (tx_idx_reg < 4'h6) begin
				tx_crc_reg <= smc_pkg::crc_step(tx_crc_reg, buf_reg[tx_idx_reg]);
			end
		end else begin
			tx_idx_reg <= 4'h0;
			tx_crc_reg <= `CRC_INIT;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.r_data <= 8'h00;
			link.r_valid <= 1'b0;
			link.r_last <= 1'b0;
		end else begin
			link.r_valid <= state_reg == smc_pkg::DEV_TX;
			link.r_last <= state_reg == smc_pkg::DEV_TX && tx_idx_reg == `RESP_LEN - 4'h1;
			case (tx_idx_reg)
				4'h6: link.r_data <= tx_crc_reg[7:0]; // [R9] [R8] [R10]
				4'h7: link.r_data <= tx_crc_reg[15:8]; // [R9]
				default: link.r_data <= buf_reg[tx_idx_reg]; // [R8] [R10]
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Motion commands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_prev_reg <= 16'h0000;
		end else begin
			word_prev_reg <= motion_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_pulse <= 1'b0;
		end else begin
			// Start bit left set does not retrigger
			start_pulse <= motion_word[`BIT_START] && !word_prev_reg[`BIT_START]; // [R3] [R11]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			forward_active <= 1'b0;
		end else if (motion_word[`BIT_FORWARD] && !word_prev_reg[`BIT_FORWARD]) begin
			forward_active <= 1'b1; // [R4] [R11]
		end else if (!motion_word[`BIT_FORWARD] && drive_speed == 32'h0000_0000) begin
			forward_active <= 1'b0; // [R5]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Speed ramp, one step per tick in both directions
	assign ramp_tick = ramp_cnt_reg == 16'(`RAMP_CYCLES - 1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ramp_cnt_reg <= 16'h0000;
		end else begin
			ramp_cnt_reg <= ramp_tick ? 16'h0000 : ramp_cnt_reg + 16'h0001;
		end
	end

	assign target = (forward_active && motion_word[`BIT_FORWARD]) ? run_speed : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_speed <= 32'h0000_0000;
		end else if (ramp_tick) begin
			if (drive_speed < target) begin
				drive_speed <= (target - drive_speed > `RAMP_STEP)
					? drive_speed + `RAMP_STEP : target; // [R4]
			end else if (drive_speed > target) begin
				// Decelerate rather than drop to zero
				drive_speed <= (drive_speed - target > `RAMP_STEP)
					? drive_speed - `RAMP_STEP : target; // [R5]
			end
		end
	end
endmodule : motion_device

// ---- logic/motion_master.sv ----
// Command master end: AHB-Lite registers, query build, reply check
`timescale 1ns/1ps
`include "smc_cfg.svh"
module motion_master (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	smc_link_if.master       link
);
	smc_pkg::mst_state_t state_reg;
	smc_pkg::byte_t      frame_reg [`RX_MAX];
	logic [31:0]         data_reg;
	logic [7:0]          slave_reg;
	logic                kind_reg;
	logic                done_reg;
	logic                ok_reg;
	logic                wr_pend_reg;
	logic [7:0]          wr_ofs_reg;
	logic                go;
	logic [3:0]          len;
	logic [3:0]          idx_reg;
	logic [15:0]         crc_reg;
	logic [15:0]         rcrc_reg;
	logic [15:0]         rcrc_next;
	logic [3:0]          rcnt_reg;
	logic                addr_ok;

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel && hready && htrans[1];
	assign go = wr_pend_reg && wr_ofs_reg == `OFS_CTRL && hwdata[`CTRL_GO]
		&& state_reg == smc_pkg::MST_IDLE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_ofs_reg <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= addr_ok && hwrite;
			wr_ofs_reg <= haddr[7:0];
			if (addr_ok && !hwrite) begin
				case (haddr[7:0])
					`OFS_CTRL: hrdata <= {30'h0000_0000, kind_reg, 1'b0};
					`OFS_DATA: hrdata <= data_reg;
					`OFS_SLAVE: hrdata <= {24'h00_0000, slave_reg};
					`OFS_STATUS: hrdata <= {29'h0000_0000, ok_reg, done_reg,
						state_reg != smc_pkg::MST_IDLE};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_reg <= 32'h0000_0000;
			slave_reg <= `SLAVE_RESET;
			kind_reg <= 1'b0;
		end else if (wr_pend_reg) begin
			case (wr_ofs_reg)
				// Kind frozen while a frame is out: the send length depends on it
				`OFS_CTRL: if (state_reg == smc_pkg::MST_IDLE) kind_reg <= hwdata[`CTRL_KIND];
				`OFS_DATA: data_reg <= hwdata;
				`OFS_SLAVE: slave_reg <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Query build and send
	assign len = kind_reg ? 4'(`LEN_MANY - 2) : 4'(`LEN_ONE - 2);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < `RX_MAX; i++) begin
				frame_reg[i] <= 8'h00;
			end
		end else if (go) begin
			frame_reg[0] <= slave_reg;
			if (hwdata[`CTRL_KIND]) begin
				// Speed entry, upper word first, upper byte first
				{frame_reg[1], frame_reg[2], frame_reg[3]} <= {`FC_WRITE_MANY, `REG_SPEED0}; // [R6]
				{frame_reg[4], frame_reg[5], frame_reg[6]} <= {`SPEED_REG_COUNT,
					`SPEED_BYTE_COUNT}; // [R6] [R7]
				{frame_reg[7], frame_reg[8], frame_reg[9], frame_reg[10]} <= data_reg;
			end else begin
				{frame_reg[1], frame_reg[2], frame_reg[3]} <= {`FC_WRITE_ONE, `REG_MOTION}; // [R1]
				// Software writes 0000h after motion starts to clear start
				{frame_reg[4], frame_reg[5]} <= data_reg[15:0]; // [R1] [R3]
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= smc_pkg::MST_IDLE;
		end else begin
			case (state_reg)
				smc_pkg::MST_IDLE: if (go) state_reg <= smc_pkg::MST_SEND;
				smc_pkg::MST_SEND: if (idx_reg == len + 4'h1) state_reg <= smc_pkg::MST_WAIT;
				smc_pkg::MST_WAIT: if (link.r_valid && link.r_last) state_reg <= smc_pkg::MST_IDLE;
				default: state_reg <= smc_pkg::MST_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_reg <= 4'h0;
			crc_reg <= `CRC_INIT;
			link.q_data <= 8'h00;
			link.q_valid <= 1'b0;
			link.q_last <= 1'b0;
		end else if (state_reg == smc_pkg::MST_SEND) begin
			idx_reg <= idx_reg + 4'h1;
			link.q_valid <= 1'b1;
			link.q_last <= idx_reg == len + 4'h1;
			if (idx_reg < len) begin
				link.q_data <= frame_reg[idx_reg];
				crc_reg <= smc_pkg::crc_step(crc_reg, frame_reg[idx_reg]); // [R9]
			end else begin
				link.q_data <= (idx_reg == len) ? crc_reg[7:0] : crc_reg[15:8]; // [R9]
			end
		end else begin
			idx_reg <= 4'h0;
			crc_reg <= `CRC_INIT;
			link.q_valid <= 1'b0;
			link.q_last <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply check: length and CRC residue
	assign rcrc_next = smc_pkg::crc_step(rcrc_reg, link.r_data);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rcrc_reg <= `CRC_INIT;
			rcnt_reg <= 4'h0;
		end else if (link.r_valid && !link.r_last) begin
			rcrc_reg <= rcrc_next;
			rcnt_reg <= rcnt_reg + 4'h1;
		end else if (link.r_valid || go) begin
			rcrc_reg <= `CRC_INIT;
			rcnt_reg <= 4'h0;
		end
	end

	// Completion beats a same-cycle restart, so no event is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_reg <= 1'b0;
			ok_reg <= 1'b0;
		end else if (state_reg == smc_pkg::MST_WAIT && link.r_valid && link.r_last) begin
			done_reg <= 1'b1;
			ok_reg <= rcrc_next == 16'h0000 && rcnt_reg == `RESP_LEN - 4'h1; // [R8] [R10]
		end else if (go) begin
			done_reg <= 1'b0;
			ok_reg <= 1'b0;
		end
	end
endmodule : motion_master

// ---- test/serial_motion_command_handler_chk.sv ----
// Link protocol checker for the motion command link
`timescale 1ns/1ps
module serial_motion_command_handler_chk (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic [7:0] q_data,
	input wire logic       q_valid,
	input wire logic       q_last,
	input wire logic [7:0] r_data,
	input wire logic       r_valid,
	input wire logic       r_last
);
	logic [3:0]  qi, ri;
	logic [7:0]  qb [0:5];
	logic [7:0]  ql, rl;
	logic [15:0] qc, qp, rc, rp;

	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		return c;
	endfunction : crc16

	// Running CRC kept one byte behind, so the last two bytes can be compared
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			qi <= 4'h0; qc <= 16'hffff; qp <= 16'hffff; ql <= 8'h00;
		end else if (q_valid) begin
			qi <= q_last ? 4'h0 : qi + 4'h1;
			qc <= q_last ? 16'hffff : crc16(qc, q_data);
			qp <= qc; ql <= q_data;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ri <= 4'h0; rc <= 16'hffff; rp <= 16'hffff; rl <= 8'h00;
		end else if (r_valid) begin
			ri <= r_last ? 4'h0 : ri + 4'h1;
			rc <= r_last ? 16'hffff : crc16(rc, r_data);
			rp <= rc; rl <= r_data;
		end
	end
	always_ff @(posedge hclk) begin
		if (q_valid && qi < 4'h6) qb[qi] <= q_data;
	end
	//////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	reply_start_a: assert property ($rose(r_valid) |-> $past(q_valid && q_last, 2))
		else $error("reply did not start two cycles after query end");
	reply_len_a: assert property ($rose(r_valid) |->
		(r_valid && !r_last)[*7] ##1 (r_valid && r_last)) else $error("reply not 8 bytes");
	reply_gap_a: assert property (r_valid && r_last |=> !r_valid)
		else $error("reply strobe after last byte");
	reply_echo_a: assert property (r_valid && ri < 4'h6 |-> r_data == qb[ri])
		else $error("reply header differs from query");
	reply_crc_a: assert property (r_valid && r_last |-> {r_data, rl} == rp)
		else $error("reply check value wrong");
	query_crc_a: assert property (q_valid && q_last |-> {q_data, ql} == qp)
		else $error("query check value wrong");
	query_func_a: assert property (q_valid && qi == 4'h1 |-> q_data inside {8'h06, 8'h10})
		else $error("query function code unknown");
	query_len_a: assert property (q_valid && q_last |->
		qi == ((qb[1] == 8'h10) ? 4'hc : 4'h7)) else $error("query length wrong");
	byte_count_a: assert property (q_valid && qi == 4'h6 && qb[1] == 8'h10 |->
		q_data == 8'h04 && qb[5] == 8'h02) else $error("byte count not twice registers");

	cover property ($rose(r_valid) && qb[1] == 8'h10);
	cover property (q_valid && q_last && qb[1] == 8'h06);
	cover property (r_valid && r_last);
endmodule : serial_motion_command_handler_chk

// ---- test/serial_motion_command_handler_bench.sv ----
// Testbench: AHB-driven master facing the motion device, plus a fault link
`timescale 1ns/1ps
module serial_motion_command_handler_bench;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hresp;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, run_speed, drive_speed;
	logic [1:0]  htrans = '0;
	logic [2:0]  hsize = 3'b010;
	logic        start_pulse, forward_active;
	logic [15:0] motion_word, mw_b;
	logic [7:0]  sa = 8'h01;
	logic [7:0]  qx[$], rx[$], qg[$], rg[$];
	int          num_errors = 0, total_checks = 0, cyc = 0, pulses = 0, r2 = 0;

	always #5 hclk = ~hclk;
	smc_link_if lnk();
	smc_link_if lnk2();
	motion_master u_motion_master (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout(hready), .hrdata, .hresp, .link(lnk));
	motion_device u_motion_device (.hclk, .hresetn, .link(lnk), .slave_addr(sa), .motion_word,
		.run_speed, .start_pulse, .forward_active, .drive_speed);
	// Second device sees frames driven by the bench: wrong address, bad CRC, then one good frame
	motion_device u_motion_device_b (.hclk, .hresetn, .link(lnk2), .slave_addr(8'h01),
		.motion_word(mw_b), .run_speed(), .start_pulse(), .forward_active(), .drive_speed());
	serial_motion_command_handler_chk u_chk (.hclk, .hresetn, .q_data(lnk.q_data),
		.q_valid(lnk.q_valid), .q_last(lnk.q_last), .r_data(lnk.r_data),
		.r_valid(lnk.r_valid), .r_last(lnk.r_last));

	always @(posedge hclk) begin
		cyc++;
		if (lnk.q_valid === 1'b1) qg.push_back(lnk.q_data);
		if (lnk.r_valid === 1'b1) rg.push_back(lnk.r_data);
		if (start_pulse === 1'b1) pulses++;
		if (lnk2.r_valid === 1'b1) r2++;
		if (cyc == 30000) begin
			num_errors++;
			stop_test();
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test

	task chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	function automatic logic [15:0] fcs(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[k]) begin
			c = c ^ {8'h00, q[k]};
			for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction : fcs

	task ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
		chk("hresp", hresp, 32'h0000_0000);
	endtask : ahb

	// Model builds the expected query and reply, then the wire is compared byte by byte
	task cmd(input logic k, input logic [31:0] d);
		logic [15:0] c;
		qg.delete(); rg.delete();
		if (k) qx = {sa, 8'h10, 8'h04, 8'h80, 8'h00, 8'h02, 8'h04, d[31:24], d[23:16], d[15:8], d[7:0]};
		else qx = {sa, 8'h06, 8'h00, 8'h7d, d[15:8], d[7:0]};
		if (k) rx = qx[0:5];
		else rx = qx;
		c = fcs(qx); qx.push_back(c[7:0]); qx.push_back(c[15:8]);
		c = fcs(rx); rx.push_back(c[7:0]); rx.push_back(c[15:8]);
		ahb(1'b1, 32'h0000_0004, d, rd);
		ahb(1'b1, 32'h0000_0000, {30'h0000_0000, k, 1'b1}, rd);
		rd = '0;
		for (int i = 0; i < 100 && rd[1] !== 1'b1; i++) ahb(1'b0, 32'h0000_000c, '0, rd);
		chk("status", rd[2:0], 3'b110);
		chk("query_len", qg.size(), qx.size());
		foreach (qx[i]) chk("query_byte", qg[i], qx[i]);
		chk("reply_len", rg.size(), rx.size());
		foreach (rx[i]) chk("reply_byte", rg[i], rx[i]);
	endtask : cmd

	task send2(input logic [7:0] f[$]);
		foreach (f[i]) begin
			@(posedge hclk);
			lnk2.q_data <= f[i]; lnk2.q_valid <= 1'b1; lnk2.q_last <= (i == f.size() - 1);
		end
		@(posedge hclk);
		lnk2.q_valid <= 1'b0; lnk2.q_last <= 1'b0;
	endtask : send2
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] sp, d;
		logic [7:0]  fr[$];
		int          p0, n;
		void'($urandom(74928));
		lnk2.q_data = '0; lnk2.q_valid = 1'b0; lnk2.q_last = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h0000_0008, '0, rd);
		chk("slave_reset", rd, 32'h0000_0001);
		ahb(1'b1, 32'h0000_0010, 32'hffff_ffff, rd);
		ahb(1'b0, 32'h0000_0010, '0, rd);
		chk("unmapped", rd, 32'h0000_0000);
		d = $urandom_range(1, 247);
		sa <= d[7:0];
		ahb(1'b1, 32'h0000_0008, d, rd);
		sp = $urandom;
		cmd(1'b1, sp);
		chk("speed_word_order", run_speed, sp);
		sp = $urandom_range(3, 20) * 100;
		cmd(1'b1, sp);
		chk("run_speed", run_speed, sp);
		ahb(1'b0, 32'h0000_0000, '0, rd);
		chk("ctrl_kind", rd, 32'h0000_0002);
		ahb(1'b0, 32'h0000_0004, '0, rd);
		chk("data_readback", rd, sp);
		p0 = pulses;
		cmd(1'b0, 32'h0000_0008);
		chk("motion_word", motion_word, 16'h0008);
		chk("start_pulses", pulses - p0, 1);
		cmd(1'b0, 32'h0000_0008);
		chk("no_retrigger", pulses - p0, 1);
		cmd(1'b0, 32'h0000_0000);
		chk("start_cleared", motion_word, 16'h0000);
		cmd(1'b0, 32'h0000_4000);
		chk("forward_on", forward_active, 1'b1);
		for (int i = 0; i < 3000 && drive_speed !== sp; i++) @(posedge hclk);
		chk("at_speed", drive_speed, sp);
		cmd(1'b0, 32'h0000_0000);
		chk("decelerating", forward_active, 1'b1);
		for (n = 0; n < 3000 && forward_active !== 1'b0; n++) @(posedge hclk);
		// Count starts about a dozen cycles after the clear, ramp phase is free
		chk("ramp_down_time", n >= (sp / 100 - 2) * 100, 1);
		chk("ramp_down_max", n <= sp, 1);
		chk("stopped", drive_speed, 32'h0000_0000);
		chk("no_start_from_run", pulses - p0, 1);
		repeat (4) begin
			d = $urandom & 32'h0000_bff7;
			cmd(1'b0, d);
			chk("motion_word_rand", motion_word, d[15:0]);
		end
		fr = {8'h02, 8'h06, 8'h00, 8'h7d, 8'h00, 8'h08};
		d = fcs(fr);
		fr.push_back(d[7:0]);
		fr.push_back(d[15:8]);
		send2(fr);
		repeat (12) @(posedge hclk);
		chk("wrong_addr_ignored", mw_b, 16'h0000);
		chk("wrong_addr_no_reply", r2, 0);
		fr = {8'h01, 8'h06, 8'h00, 8'h7d, 8'h00, 8'h08, 8'h18, 8'h15};
		send2(fr);
		repeat (12) @(posedge hclk);
		chk("bad_crc_ignored", mw_b, 16'h0000);
		chk("bad_crc_no_reply", r2, 0);
		fr[7] = 8'h14;
		send2(fr);
		repeat (12) @(posedge hclk);
		chk("good_frame", mw_b, 16'h0008);
		chk("good_reply", r2, 8);
		stop_test();
	end
endmodule : serial_motion_command_handler_bench
